// file: hw/tmr_pkg.sv
// Package for the 8-bit timer with shared scaler block.
// Assumes a 100 MHz system clock and AXI4-Lite register access.
package tmr_pkg;
  // Printed offsets (not all multiples of four): register indexes
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PORT_A_DIR = 8'h85;
  // Own register: dog clear strobe and watchdog counter view
  localparam logic [7:0] IDX_DOG_CTRL = 8'h90;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // Option register fields
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_ASSIGN = 3;
  localparam int OPT_EDGE = 4;
  localparam int OPT_SOURCE = 5;
  // Interrupt control fields
  localparam int IRQ_OVF = 2;
  // Dog control fields
  localparam int DOG_CLEAR = 0;

  // Reset values
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [4:0] PORT_A_RST = 5'h1F;
  localparam logic [7:0] TIMER_RST = 8'h00;

  // Phase clock: four system clocks per instruction cycle
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  // Inhibit after a timer write, in instruction cycles
  localparam logic [1:0] WRITE_INHIBIT = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] timer;
    logic [7:0] irq;
    logic [7:0] option;
    logic [4:0] port_a;
  } regs_t;

  typedef enum logic [0:0] {TO_TIMER, TO_DOG} owner_t;
endpackage

// file: hw/tmr_scaler.sv
// Shared 8-bit scaler counter with tap selection.
// Assumes the caller gives it one count strobe per input edge.
`timescale 1ns/1ps
module tmr_scaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic step,
  input wire logic clear,
  input wire logic [2:0] ratio,
  // Divided output level
  output logic tap
);
  logic [WIDTH-1:0] count;

  initial begin
    if (WIDTH != 8) begin
      $error("tmr_scaler supports only WIDTH 8");
    end
  end

  // Counter stepped per input edge; bit k toggles at half the rate of bit k-1
  always_ff @(posedge clock) begin
    if (!nrst || clear) begin
      count <= '0;
    end else if (step) begin
      count <= count + 1'b1;
    end
  end

  // Tap bit ratio gives a symmetric divide by two to the ratio plus one
  assign tap = count[ratio];
endmodule

// file: hw/tmr_top.sv
// Timer/counter with shared scaler, external count synchroniser and regs.
// Assumes an AXI4-Lite master and an asynchronous external count pin.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tmr_top #(
  parameter int DOG_WIDTH = 8
) (
  // System
  input wire logic clock,
  input wire logic nrst,
  // External count clock pin
  input wire logic ext_count_clock_pin,
  // AXI4-Lite write address
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status outputs
  output logic timer_overflow_flag,
  output logic dog_tick,
  output logic [4:0] port_a_direction
);
  tmr_pkg::regs_t regs;
  tmr_pkg::owner_t owner;
  logic [1:0] phase;
  logic pin_meta, pin_sync;
  logic src_level, sample, sample_prev;
  logic [1:0] inhibit;
  logic [DOG_WIDTH-1:0] dog_count;
  logic scaler_step, scaler_clear, scaler_tap;
  logic count_edge, inc;
  logic pin_prev;
  logic timer_write, option_write, dog_clear_write, irq_write;
  logic [7:0] wdata8;
  logic aw_held, w_held;
  logic [tmr_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  initial begin
    if (DOG_WIDTH < 1 || DOG_WIDTH > 31) begin
      $error("DOG_WIDTH must be 1 to 31");
    end
  end

  // Register index from a byte address
  function automatic logic [7:0] index_of(
      input logic [tmr_pkg::ADDR_W-1:0] a);
    index_of = a[tmr_pkg::IDX_LSB +: 8];
  endfunction

  // Mapped index check
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == tmr_pkg::IDX_TIMER_COUNT) ||
             (i == tmr_pkg::IDX_IRQ_CONTROL) ||
             (i == tmr_pkg::IDX_OPTION) ||
             (i == tmr_pkg::IDX_PORT_A_DIR) ||
             (i == tmr_pkg::IDX_DOG_CTRL);
  endfunction

  // Write address and data are taken separately, in either order
  always_ff @(posedge clock) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready flags, registered; low while a channel is held or a reply waits
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) &&
                       !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) &&
                      !s_axi_bvalid;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wdata8 = w_data[7:0];
  assign timer_write = do_write && w_strb[0] &&
                       index_of(aw_addr) == tmr_pkg::IDX_TIMER_COUNT;
  assign option_write = do_write && w_strb[0] &&
                        index_of(aw_addr) == tmr_pkg::IDX_OPTION;
  assign irq_write = do_write && w_strb[0] &&
                     index_of(aw_addr) == tmr_pkg::IDX_IRQ_CONTROL;
  assign dog_clear_write = do_write && w_strb[0] &&
                           index_of(aw_addr) == tmr_pkg::IDX_DOG_CTRL &&
                           wdata8[tmr_pkg::DOG_CLEAR];

  // Write response one cycle after both halves are held
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tmr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(index_of(aw_addr)) ? tmr_pkg::RESP_OKAY :
                     tmr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tmr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(index_of(s_axi_araddr)) ? tmr_pkg::RESP_OKAY :
                     tmr_pkg::RESP_SLVERR;
      // No path reads the scaler count
      case (index_of(s_axi_araddr))
        tmr_pkg::IDX_TIMER_COUNT: s_axi_rdata <= {24'h000000, regs.timer};
        tmr_pkg::IDX_IRQ_CONTROL: s_axi_rdata <= {24'h000000, regs.irq};
        tmr_pkg::IDX_OPTION: s_axi_rdata <= {24'h000000, regs.option};
        tmr_pkg::IDX_PORT_A_DIR: s_axi_rdata <= {27'h0000000, regs.port_a};
        tmr_pkg::IDX_DOG_CTRL:
          s_axi_rdata <= {{(32 - DOG_WIDTH){1'b0}}, dog_count};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Option and direction registers; new assignment acts at once
  always_ff @(posedge clock) begin
    if (!nrst) begin
      regs.option <= tmr_pkg::OPTION_RST;
      regs.port_a <= tmr_pkg::PORT_A_RST;
    end else begin
      if (option_write) begin
        regs.option <= wdata8;
      end
      if (do_write && w_strb[0] &&
          index_of(aw_addr) == tmr_pkg::IDX_PORT_A_DIR) begin
        regs.port_a <= w_data[4:0];
      end
    end
  end

  // Owner from the assign bit: zero timer, one watchdog
  assign owner = regs.option[tmr_pkg::OPT_ASSIGN] ? tmr_pkg::TO_DOG :
                 tmr_pkg::TO_TIMER;

  // Phase counter giving Q1..Q4 within each instruction cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Pin through two flip-flops before any logic
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= ext_count_clock_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Selected pin edge, inverted by the edge select bit
  assign count_edge = regs.option[tmr_pkg::OPT_EDGE] ?
                      (pin_prev && !pin_sync) : (!pin_prev && pin_sync);

  // Scaler steps on pin edges or each Q4 for the timer, by the source bit, or once per dog rollover
  always_comb begin
    if (owner == tmr_pkg::TO_TIMER) begin
      scaler_step = regs.option[tmr_pkg::OPT_SOURCE] ? count_edge :
                    (phase == tmr_pkg::PHASE_Q4);
    end else begin
      scaler_step = dog_count == '1 && phase == tmr_pkg::PHASE_Q4;
    end
  end

  // Clear by timer write or dog clear, per owner
  assign scaler_clear = (owner == tmr_pkg::TO_TIMER) ? timer_write :
                        dog_clear_write;

  // Shared divider; tap n divides by two to n plus one
  tmr_scaler #(
    .WIDTH(8)
  ) u_scaler (
    .clock(clock),
    .nrst(nrst),
    .step(scaler_step),
    .clear(scaler_clear),
    .ratio(regs.option[tmr_pkg::OPT_RATIO_LSB +: 3]),
    .tap(scaler_tap)
  );

  // Source level: scaler tap when the timer owns it, else edge-selected pin or phase[1] by the source bit
  always_comb begin
    if (owner == tmr_pkg::TO_TIMER) begin
      src_level = scaler_tap;
    end else if (regs.option[tmr_pkg::OPT_SOURCE]) begin
      src_level = regs.option[tmr_pkg::OPT_EDGE] ? !pin_sync : pin_sync;
    end else begin
      src_level = phase[1];
    end
  end

  // Sample at Q2 and Q4; reset high so no false rise follows reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sample <= 1'b1;
      sample_prev <= 1'b1;
    end else if (phase == tmr_pkg::PHASE_Q2 ||
                 phase == tmr_pkg::PHASE_Q4) begin
      sample_prev <= sample;
      sample <= src_level;
    end
  end

  // Rise between two successive samples; a rise needs two samples, so at
  // most one increment per instruction cycle
  assign inc = (phase == tmr_pkg::PHASE_Q2 || phase == tmr_pkg::PHASE_Q4) &&
               sample && !sample_prev && inhibit == 2'h0;

  // Write inhibits counting for two instruction cycles
  always_ff @(posedge clock) begin
    if (!nrst) begin
      inhibit <= 2'h0;
    end else if (timer_write) begin
      inhibit <= tmr_pkg::WRITE_INHIBIT;
    end else if (phase == tmr_pkg::PHASE_Q4 && inhibit != 2'h0) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  // Timer count; write wins over increment
  always_ff @(posedge clock) begin
    if (!nrst) begin
      regs.timer <= tmr_pkg::TIMER_RST;
    end else if (timer_write) begin
      regs.timer <= wdata8;
    end else if (inc) begin
      regs.timer <= regs.timer + 8'h01;
    end
  end

  // Interrupt control; overflow set beats software clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      regs.irq <= tmr_pkg::IRQ_RST;
    end else begin
      if (irq_write) begin
        regs.irq <= wdata8;
      end
      if (inc && regs.timer == 8'hFF && !timer_write) begin
        regs.irq[tmr_pkg::IRQ_OVF] <= 1'b1;
      end
    end
  end

  // Watchdog base count, cleared by the dog clear strobe
  always_ff @(posedge clock) begin
    if (!nrst || dog_clear_write) begin
      dog_count <= '0;
    end else if (phase == tmr_pkg::PHASE_Q4) begin
      dog_count <= dog_count + 1'b1;
    end
  end

  // Dog output: scaler tap when owned, top bit of the base count otherwise
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dog_tick <= 1'b0;
    end else if (owner == tmr_pkg::TO_DOG) begin
      dog_tick <= scaler_tap;
    end else begin
      dog_tick <= dog_count[DOG_WIDTH-1];
    end
  end

  // Registered status outputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      timer_overflow_flag <= 1'b0;
      port_a_direction <= tmr_pkg::PORT_A_RST;
    end else begin
      timer_overflow_flag <= regs.irq[tmr_pkg::IRQ_OVF];
      port_a_direction <= regs.port_a;
    end
  end
endmodule

// file: tb/tmr_pin_src.sv
// Count-clock source model for the external pin of the timer.
// Assumes the bench clock; the pin rests low between bursts.
`timescale 1ns/1ps
module tmr_pin_src #(
  parameter int HALF = 3
) (
  // Clock and request
  input wire logic clock,
  input wire logic start,
  input wire logic [9:0] edges,
  // Pin and status
  output logic pin,
  output logic busy
);
  int left = 0;
  int t = 0;
  // Pin rests low so the first edge of a burst is rising
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Each level is held HALF clocks, a burst gives edges rising edges
  always @(posedge clock) begin
    if (!busy) begin
      if (start) begin
        busy <= 1'b1;
        left <= 2 * edges;
        t <= HALF;
      end
    end else if (t > 1) begin
      t <= t - 1;
    end else begin
      t <= HALF;
      pin <= ~pin;
      left <= left - 1;
      if (left == 1) busy <= 1'b0;
    end
  end
endmodule

// file: tb/tmr_top_bench.sv
// Bench for the timer block: bus master, pin source, result checker.
// Assumes the package, design, pin model and checker compiled first.
`timescale 1ns/1ps
module tmr_top_bench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, start = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flag, tick, pin, busy;
  logic [1:0] bresp, rresp;
  logic [4:0] pa;
  logic [9:0] edges = 10'h000;
  logic [7:0] lo_q[$], hi_q[$];
  logic [1:0] rr_q[$], br_q[$];
  logic [31:0] seed = 32'h17DA1B47;
  int num_errors = 0;
  int n_tests = 0;
  always #5 clock = ~clock;
  tmr_top #(.DOG_WIDTH(4)) dut (.clock(clock), .nrst(nrst),
    .ext_count_clock_pin(pin), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_overflow_flag(flag), .dog_tick(tick),
    .port_a_direction(pa));
  tmr_pin_src src (.clock(clock), .start(start), .edges(edges),
    .pin(pin), .busy(busy));
  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail(input string what, input logic [31:0] e, s);
    num_errors++;
    $display("CHECK FAILED %s expected %h seen %h", what, e, s);
  endtask
  task automatic hang();
    num_errors++;
    end_of_test();
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Write one register byte; address and data offered together
  task automatic wr(input logic [7:0] i, d,
                    input logic [1:0] r = tmr_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    br_q.push_back(r);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Response accepted one cycle after it shows, so it must stand
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && !bready) bready <= 1'b1;
      n++;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 100);
    bready <= 1'b0;
    if (n >= 100) hang();
  endtask
  // Read one register, noting the accepted range of its low byte
  task automatic rd(input logic [7:0] i, lo, hi,
                    input logic [1:0] r = tmr_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    rr_q.push_back(r);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    // Data accepted one cycle after it shows, so it must stand
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && !rready) rready <= 1'b1;
      n++;
    end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 100);
    rready <= 1'b0;
    if (n >= 100) hang();
  endtask
  // Burst of rising edges on the pin, then time to synchronise
  task automatic pulses(input logic [9:0] e);
    int n;
    n = 0;
    repeat (10) @(posedge clock);
    edges <= e;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (busy !== 1'b0 && n < 9000);
    repeat (12) @(posedge clock);
    if (n >= 9000) hang();
  endtask
  // Takes the oldest note when a response is taken and compares
  always @(posedge clock) begin
    logic [7:0] lo, hi;
    logic [1:0] r;
    if (rvalid && rready && lo_q.size() > 0) begin
      lo = lo_q.pop_front();
      hi = hi_q.pop_front();
      r = rr_q.pop_front();
      n_tests++;
      if ((rdata[7:0] >= lo && rdata[7:0] <= hi && rdata[31:8] === 24'h0
          && rresp === r) !== 1'b1)
        fail("read", {14'h0, r, hi, lo}, {rresp, rdata[29:0]});
    end
    if (bvalid && bready && br_q.size() > 0) begin
      r = br_q.pop_front();
      n_tests++;
      if (bresp !== r) fail("bresp", {30'h0, r}, {30'h0, bresp});
    end
  end
  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clock);
    hang();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    // Reset values, unmapped place
    rd(tmr_pkg::IDX_OPTION, 8'hFF, 8'hFF);
    rd(tmr_pkg::IDX_PORT_A_DIR, 8'h1F, 8'h1F);
    rd(tmr_pkg::IDX_IRQ_CONTROL, 8'h00, 8'h00);
    rd(tmr_pkg::IDX_TIMER_COUNT, 8'h00, 8'h00);
    rd(8'h02, 8'h00, 8'h00, tmr_pkg::RESP_SLVERR);
    wr(8'h02, 8'h55, tmr_pkg::RESP_SLVERR);
    // Random direction values, read back and seen at the port
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      wr(tmr_pkg::IDX_PORT_A_DIR, seed[7:0]);
      rd(tmr_pkg::IDX_PORT_A_DIR, {3'h0, seed[4:0]}, {3'h0, seed[4:0]});
      n_tests++;
      if (pa !== seed[4:0])
        fail("port_a_direction", {27'h0, seed[4:0]}, {27'h0, pa});
    end
    // Instruction cycles counted unscaled, then overflow
    wr(tmr_pkg::IDX_OPTION, 8'h08);
    wr(tmr_pkg::IDX_TIMER_COUNT, 8'h00);
    repeat (80) @(posedge clock);
    rd(tmr_pkg::IDX_TIMER_COUNT, 8'd17, 8'd21);
    wr(tmr_pkg::IDX_TIMER_COUNT, 8'hFE);
    repeat (40) @(posedge clock);
    rd(tmr_pkg::IDX_IRQ_CONTROL, 8'h04, 8'h04);
    n_tests++;
    if (flag !== 1'b1) fail("timer_overflow_flag", 32'h1, {31'h0, flag});
    wr(tmr_pkg::IDX_IRQ_CONTROL, 8'h00);
    rd(tmr_pkg::IDX_IRQ_CONTROL, 8'h00, 8'h00);
    // Pin edges without the scaler
    wr(tmr_pkg::IDX_OPTION, 8'h28);
    wr(tmr_pkg::IDX_TIMER_COUNT, 8'h00);
    pulses(10'd5);
    rd(tmr_pkg::IDX_TIMER_COUNT, 8'd5, 8'd5);
    // Every ratio, scaler moved from the watchdog first
    for (int k = 0; k < 8; k++) begin
      wr(tmr_pkg::IDX_DOG_CTRL, 8'h01);
      // Dog clear empties the base count and an owned scaler alike
      @(posedge clock);
      n_tests++;
      if (tick !== 1'b0) fail("dog_tick", 32'h0, {31'h0, tick});
      wr(tmr_pkg::IDX_OPTION, 8'h20 | k[7:0]);
      wr(tmr_pkg::IDX_TIMER_COUNT, 8'h00);
      pulses(10'd2 << (k + 1));
      rd(tmr_pkg::IDX_TIMER_COUNT, 8'd2, 8'd2);
    end
    // Timer write clears a part-filled scaler
    pulses(10'd150);
    wr(tmr_pkg::IDX_TIMER_COUNT, 8'h10);
    pulses(10'd128);
    rd(tmr_pkg::IDX_TIMER_COUNT, 8'h11, 8'h11);
    // Move to the watchdog; timer then counts unscaled
    wr(tmr_pkg::IDX_TIMER_COUNT, 8'h00);
    wr(tmr_pkg::IDX_DOG_CTRL, 8'h01);
    wr(tmr_pkg::IDX_OPTION, 8'h2F);
    wr(tmr_pkg::IDX_DOG_CTRL, 8'h01);
    rd(tmr_pkg::IDX_DOG_CTRL, 8'h00, 8'h06);
    pulses(10'd3);
    rd(tmr_pkg::IDX_TIMER_COUNT, 8'd3, 8'd3);
    // Second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(tmr_pkg::IDX_OPTION, 8'hFF, 8'hFF);
    end_of_test();
  end
endmodule

// file: tb/tmr_top_chk.sv
// Port checker for the timer block, bound into its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module tmr_top_chk (
  // System
  input wire logic clock,
  input wire logic nrst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status
  input wire logic timer_overflow_flag,
  input wire logic dog_tick,
  input wire logic [4:0] port_a_direction
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Bus timing and holding
  b_after_write_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  r_after_read_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  w_refuse_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // Status outputs
  flag_sticky_a: assert property (
    timer_overflow_flag && !s_axi_bvalid |=> timer_overflow_flag)
    else $error("overflow flag lost");
  port_a_cause_a: assert property ($changed(port_a_direction)
    |-> $past(s_axi_bvalid)) else $error("port direction moved");
  reset_vals_a: assert property ($rose(nrst)
    |-> port_a_direction == tmr_pkg::PORT_A_RST && !timer_overflow_flag
    && !dog_tick && !s_axi_bvalid) else $error("bad reset values");
endmodule
bind tmr_top tmr_top_chk chk (.clock(clock), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_overflow_flag(timer_overflow_flag), .dog_tick(dog_tick),
  .port_a_direction(port_a_direction));
